//--- hdl/sadb_router.sv
module sadb_router
  import sadb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Configuration
  input  wire logic        i_ecc_en,
  // Master request
  input  wire logic        i_req_valid,
  input  wire sadb_req_t   i_req,
  output logic             o_req_ready,
  // Master response
  output logic             o_rsp_valid,
  output sadb_rsp_t        o_rsp,
  // Target side
  output logic             o_tgt_valid,
  output sadb_tgt_t        o_tgt,
  input  wire logic        i_tgt_done,
  input  wire logic [31:0] i_tgt_rdata,
  // Current ECC map
  output logic             o_ecc_mode
);

  sadb_rt_st_t st_r;
  sadb_rt_st_t st_nxt;
  sadb_dec_t   dec;
  logic        ecc_sync;
  logic        take;
  logic [31:0] bit_mask;

  // ECC enable arrives from outside the clock domain
  sadb_sync u_ecc_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_d       (i_ecc_en),
    .o_q       (ecc_sync)
  );

  // Address decode uses the latched ECC map only
  sadb_decode u_decode (
    .i_addr   (i_req.addr),
    .i_master (i_req.master),
    .i_priv   (i_req.priv),
    .i_ecc    (st_r.ecc),
    .o_dec    (dec)
  );

  // Request handshake
  assign o_req_ready = i_ce && st_r.state == SADB_IDLE;
  assign take        = o_req_ready && i_req_valid;
  assign bit_mask    = 32'h0000_0001 << st_r.bit_idx;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      unique case (st_r.state)
        SADB_IDLE: begin
          // Map switches only between transfers, limit and pairing together
          if (!i_req_valid) begin
            st_nxt.ecc = ecc_sync;
          end
          if (take) begin
            st_nxt.rsp          = '0;
            st_nxt.bb           = dec.bb;
            st_nxt.bb_write     = i_req.write;
            st_nxt.wbit         = i_req.wdata[0];
            st_nxt.bit_idx      = dec.bit_idx;
            st_nxt.tgt.sel      = dec.sel;
            st_nxt.tgt.addr     = dec.addr;
            st_nxt.tgt.bank     = dec.bank;
            st_nxt.tgt.chk_en   = st_r.ecc && dec.sel == SADB_T_SRAM;
            st_nxt.tgt.chk_bank = {1'b1, dec.bank[1:0]};
            st_nxt.tgt.cached   = dec.sel == SADB_T_CACHE;
            st_nxt.tgt.wdata    = i_req.wdata;
            if (dec.err) begin
              st_nxt.rsp.err = 1'b1;
              st_nxt.state   = SADB_RESP;
            end else if (dec.bb) begin
              st_nxt.tgt.write = 1'b0;
              st_nxt.state     = SADB_BBR;
            end else begin
              st_nxt.tgt.write = i_req.write;
              st_nxt.state     = SADB_ACC;
            end
          end
        end
        SADB_ACC: begin
          if (i_tgt_done) begin
            st_nxt.rsp.rdata = st_r.tgt.write ? 32'h0000_0000 : i_tgt_rdata;
            st_nxt.state     = SADB_RESP;
          end
        end
        SADB_BBR: begin
          if (i_tgt_done) begin
            if (st_r.bb_write) begin
              // Modify the one bit and write the word back
              st_nxt.tgt.write = 1'b1;
              st_nxt.tgt.wdata = st_r.wbit ? (i_tgt_rdata | bit_mask)
                                           : (i_tgt_rdata & ~bit_mask);
              st_nxt.state     = SADB_BBW;
            end else begin
              st_nxt.rsp.rdata = {31'h0000_0000, |(i_tgt_rdata & bit_mask)};
              st_nxt.state     = SADB_RESP;
            end
          end
        end
        SADB_BBW: begin
          if (i_tgt_done) begin
            st_nxt.rsp.rdata = 32'h0000_0000;
            st_nxt.state     = SADB_RESP;
          end
        end
        SADB_RESP: begin
          st_nxt.state = SADB_IDLE;
        end
        default: begin
          st_nxt.state = SADB_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign o_rsp_valid = st_r.state == SADB_RESP;
  assign o_rsp       = st_r.rsp;
  assign o_tgt       = st_r.tgt;
  assign o_ecc_mode  = st_r.ecc;
  assign o_tgt_valid = st_r.state == SADB_ACC || st_r.state == SADB_BBR ||
                       st_r.state == SADB_BBW;

  // Checks on routing and responses
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_sram_alias_dma: assert property (
    take && i_req.master != SADB_M_SYS &&
    i_req.addr >= SADB_SRAM_AL_BASE && i_req.addr <= SADB_SRAM_AL_END
    |=> o_rsp_valid && o_rsp.err)
    else $error("non-core SRAM alias access not refused");

  a_peri_alias_dma: assert property (
    take && i_req.master == SADB_M_DMA &&
    i_req.addr >= SADB_PERI_AL_BASE && i_req.addr <= SADB_PERI_AL_END
    |=> o_rsp_valid && o_rsp.err)
    else $error("non-core peripheral alias access not refused");

  a_ppb_refuse: assert property (
    take && i_req.addr >= SADB_PPB_BASE && i_req.addr <= SADB_PPB_END &&
    (i_req.master != SADB_M_SYS || !i_req.priv)
    |=> o_rsp_valid && o_rsp.err && !o_tgt_valid)
    else $error("private peripheral access not refused");

  a_vendor_err: assert property (
    take && i_req.addr >= SADB_VEND_BASE |=> o_rsp_valid && o_rsp.err)
    else $error("vendor region access did not error");

  a_sram_limit: assert property (
    take && i_req.master == SADB_M_SYS &&
    i_req.addr > (st_r.ecc ? SADB_SRAM_END_ECC : SADB_SRAM_END_PLAIN) &&
    i_req.addr <= SADB_SRAM_BB_END
    |=> o_rsp_valid && o_rsp.err)
    else $error("access past usable SRAM not refused");

  a_apb_route: assert property (
    take && i_req.master inside {SADB_M_SYS, SADB_M_DMA} &&
    i_req.addr >= SADB_PERI_BASE && i_req.addr <= SADB_PERI_BB_END
    |=> o_tgt_valid && o_tgt.sel == SADB_T_APB && o_tgt.addr == $past(i_req.addr))
    else $error("low peripheral access not routed to bridge");

  a_bb_read_bit: assert property (
    o_rsp_valid && st_r.bb && !st_r.bb_write && !o_rsp.err
    |-> o_rsp.rdata[31:1] == 31'h0000_0000)
    else $error("alias read returned more than one bit");

  a_bb_rmw_write: assert property (
    st_r.state == SADB_BBR && i_tgt_done && i_ce && st_r.bb_write
    |=> o_tgt_valid && o_tgt.write &&
        o_tgt.wdata[st_r.bit_idx] == st_r.wbit &&
        o_tgt.addr == $past(o_tgt.addr))
    else $error("alias write did not modify the addressed bit");

  a_chk_pair: assert property (
    o_tgt_valid && o_tgt.chk_en
    |-> o_tgt.sel == SADB_T_SRAM && o_tgt.bank[2] == 1'b0 &&
        o_tgt.chk_bank == {1'b1, o_tgt.bank[1:0]} && st_r.ecc)
    else $error("check bank pairing wrong");

  a_icode_cache: assert property (
    take && i_req.master == SADB_M_ICODE &&
    i_req.addr >= SADB_FLASH_BASE && i_req.addr <= SADB_FLASH_END
    |=> o_tgt_valid && o_tgt.sel == SADB_T_CACHE && o_tgt.cached)
    else $error("fetch not served by cache");

  a_ecc_stable: assert property (
    st_r.state != SADB_IDLE |=> $stable(st_r.ecc))
    else $error("ECC map changed during a transfer");

  // Map, bank and alias translation checks
  a_sram_plain_ok: assert property (
    take && !st_r.ecc && i_req.master inside {SADB_M_SYS, SADB_M_DMA} &&
    i_req.addr >= SADB_SRAM_BASE && i_req.addr <= SADB_SRAM_END_PLAIN
    |=> o_tgt_valid && o_tgt.sel == SADB_T_SRAM && !o_tgt.chk_en)
    else $error("SRAM word not routed without ECC");

  a_sram_ecc_ok: assert property (
    take && st_r.ecc && i_req.master inside {SADB_M_SYS, SADB_M_DMA} &&
    i_req.addr >= SADB_SRAM_BASE && i_req.addr <= SADB_SRAM_END_ECC
    |=> o_tgt_valid && o_tgt.sel == SADB_T_SRAM && o_tgt.chk_en)
    else $error("SRAM word not routed with ECC");

  a_chk_ecc_only: assert property (
    o_tgt_valid && o_tgt.sel == SADB_T_SRAM
    |-> o_tgt.chk_en == st_r.ecc)
    else $error("check bank use does not follow ECC map");

  a_bank_range: assert property (
    o_tgt_valid && o_tgt.sel == SADB_T_SRAM
    |-> o_tgt.addr >= SADB_BANK_START[o_tgt.bank] &&
        (o_tgt.bank == 3'h7 || o_tgt.addr < SADB_BANK_START[o_tgt.bank + 3'h1]))
    else $error("SRAM word given to the wrong bank");

  a_sram_alias_map: assert property (
    take && !dec.err && i_req.addr >= SADB_SRAM_AL_BASE && i_req.addr <= SADB_SRAM_AL_END
    |=> o_tgt_valid && o_tgt.addr == SADB_SRAM_BASE +
        ((($past(i_req.addr) - SADB_SRAM_AL_BASE) >> 5) & 32'h000F_FFFC))
    else $error("SRAM alias word on wrong primary word");

  a_peri_alias_map: assert property (
    take && !dec.err && i_req.addr >= SADB_PERI_AL_BASE && i_req.addr <= SADB_PERI_AL_END
    |=> o_tgt_valid && o_tgt.addr == SADB_PERI_BASE +
        ((($past(i_req.addr) - SADB_PERI_AL_BASE) >> 5) & 32'h000F_FFFC))
    else $error("peripheral alias word on wrong primary word");

  // Single-bit read and read-modify-write checks
  a_bb_read_value: assert property (
    st_r.state == SADB_BBR && i_tgt_done && i_ce && !st_r.bb_write
    |=> o_rsp_valid && o_rsp.rdata == {31'h0000_0000, $past(i_tgt_rdata[st_r.bit_idx])})
    else $error("alias read returned the wrong bit");

  a_bb_rmw_keep: assert property (
    st_r.state == SADB_BBR && i_tgt_done && i_ce && st_r.bb_write
    |=> ((o_tgt.wdata ^ $past(i_tgt_rdata)) & ~(32'h0000_0001 << st_r.bit_idx)) == 32'h0000_0000)
    else $error("alias write disturbed other bits");

  // Peripheral, code space and privilege checks
  a_ahb_route: assert property (
    take && i_req.master inside {SADB_M_SYS, SADB_M_DMA} &&
    i_req.addr > SADB_PERI_BB_END && i_req.addr <= SADB_PERI_END &&
    !(i_req.addr >= SADB_PERI_AL_BASE && i_req.addr <= SADB_PERI_AL_END)
    |=> o_tgt_valid && o_tgt.sel == SADB_T_AHBP)
    else $error("upper peripheral access misrouted");

  a_sram_uncached: assert property (
    o_tgt_valid && o_tgt.sel != SADB_T_CACHE |-> !o_tgt.cached)
    else $error("non-cache target marked cached");

  a_icode_sram_err: assert property (
    take && i_req.master == SADB_M_ICODE &&
    i_req.addr >= SADB_SRAM_BASE && i_req.addr <= SADB_SRAM_END_PLAIN
    |=> o_rsp_valid && o_rsp.err && !o_tgt_valid)
    else $error("SRAM fetch taken on fetch master");

  a_ppb_grant: assert property (
    take && i_req.master == SADB_M_SYS && i_req.priv &&
    i_req.addr >= SADB_PPB_BASE && i_req.addr <= SADB_PPB_END
    |=> o_tgt_valid && o_tgt.sel == SADB_T_PPB)
    else $error("privileged private access refused");

  a_dcode_flash: assert property (
    take && i_req.master == SADB_M_DCODE &&
    i_req.addr >= SADB_FLASH_BASE && i_req.addr <= SADB_FLASH_END
    |=> o_tgt_valid && o_tgt.sel == SADB_T_FLASH)
    else $error("code-data read not sent to flash");

  a_dcode_info: assert property (
    take && i_req.master == SADB_M_DCODE &&
    i_req.addr >= SADB_INFO_BASE && i_req.addr <= SADB_INFO_END
    |=> o_tgt_valid && o_tgt.sel == SADB_T_INFO)
    else $error("code-data read not sent to info block");

  // Error responses and map switching
  a_err_no_data: assert property (
    o_rsp_valid && o_rsp.err |-> o_rsp.rdata == 32'h0000_0000)
    else $error("error response carried data");

  a_err_no_target: assert property (
    take && dec.err
    |=> o_rsp_valid && o_rsp.err && !o_tgt_valid)
    else $error("refused access reached a target");

  a_ecc_follow: assert property (
    st_r.state == SADB_IDLE && !i_req_valid && i_ce |=> o_ecc_mode == $past(ecc_sync))
    else $error("ECC map did not follow enable in idle");

endmodule

//--- hdl/sadb_pkg.sv
// Behaviour
// - No ECC: SRAM decodes 0x20000000 to 0x20031FFF
// - ECC on: SRAM decodes up to 0x20027FFF
// - Eight SRAM banks at their fixed starts
// - ECC on: banks five-eight hold check bits
// - SRAM alias at 0x22000000, word per bit
// - SRAM primary region ends at 0x200FFFFF
// - Alias read returns bit; write does RMW
// - Non-core SRAM alias access gets error
// - Peripheral alias maps onto 0x40000000 region
// - Non-core peripheral alias access gets error
// - Low peripheral region goes through bridge
// - Peripheral space ends at 0x5FFFFFFF
// - SRAM fetches use system master, uncached
// - Private peripherals reachable by core only
// - Private peripherals need privileged mode
// - Vendor region left unimplemented
// - Fetch master served by cache
// - Code-data master reaches flash, info block
// - Flash at 0x10000000 to 0x100FFFFF
// - System master reaches SRAM and peripherals
// - DMA reaches SRAM and peripherals, not the alias windows or private peripherals
package sadb_pkg;

  // Address map
  localparam logic [31:0] SADB_CODE_END       = 32'h1FFF_FFFF;
  localparam logic [31:0] SADB_FLASH_BASE     = 32'h1000_0000;
  localparam logic [31:0] SADB_FLASH_END      = 32'h100F_FFFF;
  localparam logic [31:0] SADB_INFO_BASE      = 32'h1080_0000;
  localparam logic [31:0] SADB_INFO_END       = 32'h1080_3FFF;
  localparam logic [31:0] SADB_SRAM_BASE      = 32'h2000_0000;
  localparam logic [31:0] SADB_SRAM_END_PLAIN = 32'h2003_1FFF;
  localparam logic [31:0] SADB_SRAM_END_ECC   = 32'h2002_7FFF;
  localparam logic [31:0] SADB_SRAM_BB_END    = 32'h200F_FFFF;
  localparam logic [31:0] SADB_SRAM_AL_BASE   = 32'h2200_0000;
  localparam logic [31:0] SADB_SRAM_AL_END    = 32'h23FF_FFFF;
  localparam logic [31:0] SADB_PERI_BASE      = 32'h4000_0000;
  localparam logic [31:0] SADB_PERI_BB_END    = 32'h400F_FFFF;
  localparam logic [31:0] SADB_PERI_AL_BASE   = 32'h4200_0000;
  localparam logic [31:0] SADB_PERI_AL_END    = 32'h43FF_FFFF;
  localparam logic [31:0] SADB_PERI_END       = 32'h5FFF_FFFF;
  localparam logic [31:0] SADB_PPB_BASE       = 32'hE000_0000;
  localparam logic [31:0] SADB_PPB_END        = 32'hE00F_FFFF;
  localparam logic [31:0] SADB_VEND_BASE      = 32'hE010_0000;

  // SRAM bank start addresses, lowest first
  localparam logic [31:0] SADB_BANK_START [0:7] = '{
    32'h2000_0000, 32'h2000_4000, 32'h2000_8000, 32'h2001_8000,
    32'h2002_8000, 32'h2002_9000, 32'h2002_A000, 32'h2002_E000};

  // Bus masters
  typedef enum logic [1:0] {
    SADB_M_ICODE = 2'h0,
    SADB_M_DCODE = 2'h1,
    SADB_M_SYS   = 2'h2,
    SADB_M_DMA   = 2'h3
  } sadb_master_t;

  // Downstream targets
  typedef enum logic [2:0] {
    SADB_T_NONE  = 3'h0,
    SADB_T_CACHE = 3'h1,
    SADB_T_FLASH = 3'h2,
    SADB_T_INFO  = 3'h3,
    SADB_T_SRAM  = 3'h4,
    SADB_T_APB   = 3'h5,
    SADB_T_AHBP  = 3'h6,
    SADB_T_PPB   = 3'h7
  } sadb_tgt_sel_t;

  // Router states
  typedef enum logic [2:0] {
    SADB_IDLE = 3'h0,
    SADB_ACC  = 3'h1,
    SADB_BBR  = 3'h2,
    SADB_BBW  = 3'h3,
    SADB_RESP = 3'h4
  } sadb_state_t;

  typedef struct packed {
    logic [31:0]  addr;
    logic [31:0]  wdata;
    logic         write;
    sadb_master_t master;
    logic         priv;
  } sadb_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } sadb_rsp_t;

  typedef struct packed {
    sadb_tgt_sel_t sel;
    logic [31:0]   addr;
    logic          write;
    logic [31:0]   wdata;
    logic [2:0]    bank;
    logic          chk_en;
    logic [2:0]    chk_bank;
    logic          cached;
  } sadb_tgt_t;

  typedef struct packed {
    logic          err;
    logic          bb;
    sadb_tgt_sel_t sel;
    logic [31:0]   addr;
    logic [2:0]    bank;
    logic [4:0]    bit_idx;
  } sadb_dec_t;

  typedef struct packed {
    sadb_state_t state;
    logic        ecc;
    sadb_tgt_t   tgt;
    logic        bb;
    logic        bb_write;
    logic        wbit;
    logic [4:0]  bit_idx;
    sadb_rsp_t   rsp;
  } sadb_rt_st_t;

  // Bank holding a byte address inside SRAM
  function automatic logic [2:0] sadb_bank_of(input logic [31:0] a);
    logic [2:0] b;
    b = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (a >= SADB_BANK_START[i]) begin
        b = 3'(i);
      end
    end
    return b;
  endfunction

  // Primary word address behind an alias word
  function automatic logic [31:0] sadb_bb_word(input logic [31:0] a,
                                               input logic [31:0] base);
    return base | {12'h000, a[24:7], 2'b00};
  endfunction

endpackage

//--- hdl/sadb_sync.sv
module sadb_sync
  import sadb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Level in and out
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sadb_sync_st_t;

  sadb_sync_st_t st_r;
  sadb_sync_st_t st_nxt;

  // Two-stage shift, held while the enable is low
  always_comb begin
    st_nxt = st_r;
    if (i_ce) begin
      st_nxt.s1 = i_d;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_q = st_r.s2;

endmodule

//--- hdl/sadb_decode.sv
module sadb_decode
  import sadb_pkg::*;
(
  // Request seen by the decoder
  input  wire logic [31:0]  i_addr,
  input  wire sadb_master_t i_master,
  input  wire logic         i_priv,
  input  wire logic         i_ecc,
  // Decode result
  output sadb_dec_t         o_dec
);

  logic        sram_al;
  logic        peri_al;
  logic [31:0] eff;
  logic [31:0] sram_lim;

  // Alias windows and usable SRAM limit
  always_comb begin
    sram_al  = i_addr >= SADB_SRAM_AL_BASE && i_addr <= SADB_SRAM_AL_END;
    peri_al  = i_addr >= SADB_PERI_AL_BASE && i_addr <= SADB_PERI_AL_END;
    sram_lim = i_ecc ? SADB_SRAM_END_ECC : SADB_SRAM_END_PLAIN;
    if (sram_al) begin
      eff = sadb_bb_word(i_addr, SADB_SRAM_BASE);
    end else if (peri_al) begin
      eff = sadb_bb_word(i_addr, SADB_PERI_BASE);
    end else begin
      eff = i_addr;
    end
  end

  // Per-master access scope
  always_comb begin
    o_dec         = '0;
    o_dec.err     = 1'b1;
    o_dec.sel     = SADB_T_NONE;
    o_dec.addr    = eff;
    o_dec.bb      = sram_al || peri_al;
    o_dec.bit_idx = i_addr[6:2];
    o_dec.bank    = sadb_bank_of(eff);
    unique case (i_master)
      SADB_M_ICODE: begin
        if (i_addr <= SADB_CODE_END && i_addr >= SADB_FLASH_BASE &&
            i_addr <= SADB_FLASH_END) begin
          o_dec.sel = SADB_T_CACHE;
          o_dec.err = 1'b0;
        end
      end
      SADB_M_DCODE: begin
        if (i_addr >= SADB_FLASH_BASE && i_addr <= SADB_FLASH_END) begin
          o_dec.sel = SADB_T_FLASH;
          o_dec.err = 1'b0;
        end else if (i_addr >= SADB_INFO_BASE && i_addr <= SADB_INFO_END) begin
          o_dec.sel = SADB_T_INFO;
          o_dec.err = 1'b0;
        end
      end
      default: begin
        // System and DMA masters share the off-core map
        if ((sram_al || peri_al) && i_master != SADB_M_SYS) begin
          o_dec.err = 1'b1;
        end else if (eff >= SADB_SRAM_BASE && eff <= sram_lim) begin
          o_dec.sel = SADB_T_SRAM;
          o_dec.err = 1'b0;
        end else if (eff >= SADB_PERI_BASE && eff <= SADB_PERI_BB_END) begin
          o_dec.sel = SADB_T_APB;
          o_dec.err = 1'b0;
        end else if (eff > SADB_PERI_BB_END && eff <= SADB_PERI_END) begin
          o_dec.sel = SADB_T_AHBP;
          o_dec.err = 1'b0;
        end else if (eff >= SADB_PPB_BASE && eff <= SADB_PPB_END &&
                     i_master == SADB_M_SYS && i_priv) begin
          o_dec.sel = SADB_T_PPB;
          o_dec.err = 1'b0;
        end
        // Vendor space and all else stays an error
      end
    endcase
  end

endmodule

//--- testbench/sadb_tgt_model.sv
module sadb_tgt_model
  import sadb_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Answer delay in cycles
  input  wire logic [3:0]  i_delay,
  // Target access from the router
  input  wire logic        i_tgt_valid,
  input  wire sadb_tgt_t   i_tgt,
  output logic             o_tgt_done,
  output logic [31:0]      o_tgt_rdata,
  // Last completed access and access count
  output sadb_tgt_t        o_last,
  output logic [15:0]      o_count
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [31:0] mem [logic [31:0]];
  logic [3:0]  wait_r;

  // Answers each access after i_delay cycles; the data bus toggles when not answering
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tgt_done <= 1'b0;
      o_tgt_rdata <= 32'h0;
      o_last <= '0;
      o_count <= 16'h0;
      wait_r <= 4'h0;
    end else if (o_tgt_done) begin
      o_tgt_done <= 1'b0;
      o_tgt_rdata <= ~o_tgt_rdata;
      wait_r <= 4'h0;
    end else if (i_tgt_valid && wait_r == i_delay) begin
      o_tgt_done <= 1'b1;
      o_last <= i_tgt;
      o_count <= o_count + 16'h1;
      if (i_tgt.write) begin
        mem[i_tgt.addr] = i_tgt.wdata;
        o_tgt_rdata <= ~o_tgt_rdata;
      end else begin
        o_tgt_rdata <= mem.exists(i_tgt.addr) ? mem[i_tgt.addr] : ~i_tgt.addr;
      end
    end else begin
      o_tgt_rdata <= ~o_tgt_rdata;
      if (i_tgt_valid) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

//--- testbench/system_address_decode_bitband_tb.sv
module system_address_decode_bitband_tb
  import sadb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ecc_en = 1'b0;
  logic        req_valid = 1'b0;
  sadb_req_t   req = '0;
  logic [3:0]  delay = 4'h0;
  logic        req_ready, rsp_valid, tgt_valid, tgt_done, ecc_mode;
  sadb_rsp_t   rsp;
  sadb_tgt_t   tgt, last;
  logic [31:0] tgt_rdata;
  logic [15:0] count;
  int          mismatches = 0;
  int          n_compared = 0;

  // Clock
  always #10 ref_clk = ~ref_clk;

  sadb_router dut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_ecc_en(ecc_en),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
    .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_tgt_valid(tgt_valid), .o_tgt(tgt),
    .i_tgt_done(tgt_done), .i_tgt_rdata(tgt_rdata), .o_ecc_mode(ecc_mode));

  sadb_tgt_model far (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_delay(delay), .i_tgt_valid(tgt_valid),
    .i_tgt(tgt), .o_tgt_done(tgt_done), .o_tgt_rdata(tgt_rdata), .o_last(last),
    .o_count(count));

  // Verdict and end of run
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One request, held until ready is seen high, left at the edge after the answer
  task automatic xfer(input logic [31:0] a, input sadb_master_t m, input logic p,
                      input logic w, input logic [31:0] d, output sadb_rsp_t r);
    int n;
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: d, write: w, master: m, priv: p};
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    check({31'h0, req_ready}, 32'h1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    check({31'h0, rsp_valid}, 32'h1);
    check({31'h0, req_ready}, 32'h0);
    r = rsp;
    @(posedge ref_clk);
  endtask

  // Read, then judge error flag, target choice, and silence of the target on errors
  task automatic route(input logic [31:0] a, input sadb_master_t m, input logic p,
                       input logic e, input sadb_tgt_sel_t s);
    sadb_rsp_t r;
    logic [15:0] c;
    c = count;
    xfer(a, m, p, 1'b0, 32'h0, r);
    check({31'h0, r.err}, {31'h0, e});
    if (e) begin
      check(r.rdata, 32'h0);
      check({16'h0, count}, {16'h0, c});
    end else begin
      check({29'h0, last.sel}, {29'h0, s});
    end
  endtask

  // Full map without error correction: every bank and the top word
  task automatic t_sram_map();
    for (int i = 0; i < 8; i++) begin
      route(SADB_BANK_START[i], SADB_M_SYS, 1'b0, 1'b0, SADB_T_SRAM);
      check({29'h0, last.bank}, 32'(i));
    end
    route(32'h2003_1FFC, SADB_M_DMA, 1'b0, 1'b0, SADB_T_SRAM);
    route(32'h2003_2000, SADB_M_SYS, 1'b0, 1'b1, SADB_T_NONE);
    check({31'h0, last.cached}, 32'h0);
  endtask

  // Single-bit read and clear through the SRAM alias window
  task automatic t_bitband_sram();
    sadb_rsp_t r;
    xfer(32'h2000_0010, SADB_M_SYS, 1'b0, 1'b1, 32'h0000_0020, r);
    xfer(32'h2200_0214, SADB_M_SYS, 1'b0, 1'b0, 32'h0, r);
    check(r.rdata, 32'h1);
    xfer(32'h2200_0214, SADB_M_SYS, 1'b0, 1'b1, 32'h0, r);
    check({31'h0, last.write}, 32'h1);
    check(last.addr, 32'h2000_0010);
    check(last.wdata, 32'h0);
    xfer(32'h2200_0214, SADB_M_SYS, 1'b0, 1'b0, 32'h0, r);
    check(r.rdata, 32'h0);
    route(32'h2200_0214, SADB_M_DMA, 1'b0, 1'b1, SADB_T_NONE);
  endtask

  // Peripheral alias for core and DMA, bridge and high-speed peripherals
  task automatic t_periph();
    route(32'h4200_0000, SADB_M_SYS, 1'b0, 1'b0, SADB_T_APB);
    check(last.addr, 32'h4000_0000);
    route(32'h43FF_FFFC, SADB_M_DMA, 1'b0, 1'b1, SADB_T_NONE);
    route(32'h400F_FFFC, SADB_M_DMA, 1'b0, 1'b0, SADB_T_APB);
    route(32'h4000_0400, SADB_M_SYS, 1'b0, 1'b0, SADB_T_APB);
    route(32'h4010_0000, SADB_M_SYS, 1'b0, 1'b0, SADB_T_AHBP);
    route(32'h5FFF_FFFC, SADB_M_SYS, 1'b0, 1'b0, SADB_T_AHBP);
  endtask

  // Private peripherals, vendor region
  task automatic t_private();
    route(32'hE000_0000, SADB_M_SYS, 1'b1, 1'b0, SADB_T_PPB);
    route(32'hE00F_FFFC, SADB_M_SYS, 1'b0, 1'b1, SADB_T_NONE);
    route(32'hE000_0000, SADB_M_DMA, 1'b1, 1'b1, SADB_T_NONE);
    route(32'hE010_0000, SADB_M_SYS, 1'b1, 1'b1, SADB_T_NONE);
  endtask

  // Code space masters
  task automatic t_code();
    route(32'h1000_0000, SADB_M_ICODE, 1'b0, 1'b0, SADB_T_CACHE);
    check({31'h0, last.cached}, 32'h1);
    route(32'h100F_FFFC, SADB_M_DCODE, 1'b0, 1'b0, SADB_T_FLASH);
    route(32'h1080_3FFC, SADB_M_DCODE, 1'b0, 1'b0, SADB_T_INFO);
    route(32'h2000_0000, SADB_M_ICODE, 1'b0, 1'b1, SADB_T_NONE);
  endtask

  // Map with error correction on: smaller SRAM and check-bank pairing
  task automatic t_ecc_map();
    ecc_en <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check({31'h0, ecc_mode}, 32'h1);
    route(32'h2002_7FFC, SADB_M_SYS, 1'b0, 1'b0, SADB_T_SRAM);
    check({31'h0, last.chk_en}, 32'h1);
    check({29'h0, last.chk_bank}, 32'h7);
    route(32'h2000_0000, SADB_M_DMA, 1'b0, 1'b0, SADB_T_SRAM);
    check({29'h0, last.chk_bank}, 32'h4);
    route(32'h2002_8000, SADB_M_SYS, 1'b0, 1'b1, SADB_T_NONE);
    route(32'h2200_0000 | (32'h2_8000 << 5), SADB_M_SYS, 1'b0, 1'b1, SADB_T_NONE);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_sram_map();
    t_bitband_sram();
    delay <= 4'h3;
    t_periph();
    t_private();
    t_code();
    t_ecc_map();
    give_verdict();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end
endmodule
